// ### tras_pkg.sv
// Constants and types for the receive alarm and signaling block.
// Assumes one received line bit per core_clk cycle from the framer.
package tras_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_MARK_LOW = 8'h04;
	localparam logic [7:0] ADDR_MARK_MID = 8'h08;
	localparam logic [7:0] ADDR_MARK_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_STATUS_PEEK = 8'h14;
	localparam logic [7:0] ADDR_MASK = 8'h18;
	localparam logic [7:0] ADDR_VIOL_CNT = 8'h1c;
	localparam logic [7:0] ADDR_ERR_CNT = 8'h20;
	localparam logic [7:0] ADDR_CONFIG = 8'h24;

	// Field positions
	localparam int CTRL_CODE_SEL = 4;
	localparam int CTRL_INSERT_EN = 5;
	localparam int CFG_ESF_MODE = 0;
	localparam int ST_LOSS_SYNC = 0;
	localparam int ST_BLUE = 1;
	localparam int ST_ZERO_SUB = 2;
	localparam int ST_FBIT_ERR = 3;
	localparam int ST_CARRIER = 4;
	localparam int ST_YELLOW = 5;
	localparam int ST_ERR_SAT = 6;
	localparam int ST_VIOL_SAT = 7;

	// Register values
	localparam logic [7:0] DIRECT_BITS = 8'h3f;
	localparam logic [7:0] ALL_ONES8 = 8'hff;
	localparam logic [3:0] ALL_ONES4 = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Stream timing
	localparam int SERIAL_DELAY = 13;
	localparam int CH_BITS = 8;
	localparam int SIG_TAP = SERIAL_DELAY - CH_BITS;
	localparam int LINK_TAP = SERIAL_DELAY - 2;
	localparam logic [7:0] LAST_BIT = 8'hc0;
	localparam logic [5:0] CARRIER_RUN_LAST = 6'h1f;
	localparam logic [1:0] BLUE_MIN_ZEROS = 2'h3;
	localparam logic [4:0] FRAME_MF_FIRST = 5'h01;
	localparam logic [4:0] FRAME_SIG_A = 5'h06;
	localparam logic [4:0] FRAME_SIG_B = 5'h0c;
	localparam logic [4:0] FRAME_SIG_C = 5'h12;
	localparam logic [4:0] FRAME_SIG_D = 5'h18;

	// Inserted codes
	localparam logic [7:0] IDLE_CODE = 8'h7f;
	localparam logic [63:0] MILLIWATT_SEQ = 64'h1e0b0b1e9e8b8b9e;

	typedef struct packed {
		logic yellow;
		logic fbit_error;
		logic zero_sub;
		logic bipolar_violation;
		logic oof_event;
		logic crc_error;
		logic loss_of_sync;
	} tras_line_events_t;

	typedef struct packed {
		logic yellow;
		logic carrier_loss;
		logic blue;
		logic loss_of_sync;
	} tras_alarms_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_held;
		logic w_held;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic [7:0] control;
		logic [23:0] mark;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] viol_cnt;
		logic [3:0] oof_cnt;
		logic [3:0] esf_cnt;
		logic esf_mode;
		logic [SERIAL_DELAY-1:0] shift;
		logic [7:0] bit_idx;
		logic [2:0] mw_phase;
		logic [5:0] zero_run;
		logic [1:0] frame_zeros;
		logic low_prev;
		logic serial_out;
		logic sig_out;
		logic link_out;
		logic mf_sync;
		logic sig_frame;
		logic sig_select;
		tras_alarms_t alarms;
		logic irq;
	} tras_state_t;

endpackage : tras_pkg

// ### tras_rx_alarm_signaling.sv
// Receive alarm reporting, interrupt servicing and signaling outputs.
// Assumes framer timing and event pulses aligned to the bit loaded into
// the serial output register, and an AXI4-Lite master at the registers.
//
// How it works
// - Drive each channel's robbed bit per slot
// - Signaling output changes at channel boundaries
// - Non-signaling frames carry channel word LSB
// - Superframe: S-bit one bit early, two frames
// - Extended: link bit before odd frames
// - Superframe link changes on even boundaries
// - Serial output lags line by 14 clocks
// - 24 mark bits in three byte registers
// - Alarm output pins plus latched status bits
// - Direct and counter-overflow interrupt sources
// - Each alarm gated by own mask bit
// - Clearing mask bit clears pending interrupt
// - Status read clears inactive direct alarms
// - Counter preset not all ones clears overflow
// - Peek status read leaves flags alone
// - Presettable counters flag events once saturated
// - Bit 7: violation counter saturation
// - Bit 5: yellow alarm detected
// - Bit 4: 32 zeros, carrier loss
// - Bit 3: framing bit error
// - Bit 2: zero substitution code seen
// - Bit 1: blue alarm, two sparse frames
// - Bit 0: latched loss of sync
// - Insertion enable and idle/milliwatt select
`timescale 1ns/1ps

module tras_rx_alarm_signaling (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Line inputs and frame timing
	input wire logic line_in_positive,
	input wire logic line_in_negative,
	input wire logic frame_fbit,
	input wire logic [4:0] frame_count,
	input wire tras_pkg::tras_line_events_t line_events,
	// Serial outputs
	output logic rx_serial_out,
	output logic rx_signaling_out,
	output logic rx_link_out,
	output logic rx_multiframe_sync,
	output logic rx_signaling_frame_ind,
	output logic rx_signaling_select,
	// Alarm pins and interrupt
	output tras_pkg::tras_alarms_t alarm_out,
	output logic irq
);

	tras_pkg::tras_state_t s;
	tras_pkg::tras_state_t n;

	logic [7:0] cur_idx;
	logic [7:0] slot;
	logic [4:0] ch;
	logic [2:0] chbit;
	logic in_slot;
	logic boundary;
	logic sig_frame;
	logic line_bit;
	logic insert;
	logic [7:0] mw_byte;
	logic [7:0] code_byte;
	logic low_zero;
	logic esf_ev;
	logic wr_go;
	logic wr_map;
	logic wr_ok;
	logic rd_go;
	logic rd_map;
	logic [7:0] rd_byte;
	logic [7:0] set_v;
	logic [7:0] clr_v;

	always_comb begin
		n = s;
		set_v = '0;
		clr_v = '0;

		// Bit position within the frame being loaded
		cur_idx = frame_fbit ? 8'h00 : s.bit_idx;
		n.bit_idx = cur_idx + 8'h01;
		in_slot = (cur_idx != 8'h00) && (cur_idx <= tras_pkg::LAST_BIT);
		slot = cur_idx - 8'h01;
		ch = slot[7:3];
		chbit = slot[2:0];
		boundary = in_slot && (chbit == 3'h0);
		case (frame_count)
			tras_pkg::FRAME_SIG_A,
			tras_pkg::FRAME_SIG_B,
			tras_pkg::FRAME_SIG_C,
			tras_pkg::FRAME_SIG_D: sig_frame = 1'h1;
			default: sig_frame = 1'h0;
		endcase

		n.shift = {s.shift[tras_pkg::SERIAL_DELAY-2:0],
			line_in_positive | line_in_negative};
		line_bit = s.shift[tras_pkg::SERIAL_DELAY-1];

		if (frame_fbit) begin
			n.mw_phase = s.mw_phase + 3'h1;
		end
		mw_byte = tras_pkg::MILLIWATT_SEQ[{3'(3'h7 - s.mw_phase), 3'h0} +: 8];
		code_byte = s.control[tras_pkg::CTRL_CODE_SEL] ? mw_byte
			: tras_pkg::IDLE_CODE;
		insert = in_slot && s.control[tras_pkg::CTRL_INSERT_EN]
			&& s.mark[ch];
		n.serial_out = insert ? code_byte[3'h7 - chbit] : line_bit;

		if (boundary) begin
			n.sig_out = s.shift[tras_pkg::SIG_TAP];
		end
		n.sig_frame = sig_frame;
		n.mf_sync = (frame_count == tras_pkg::FRAME_MF_FIRST);
		n.sig_select = (frame_count == tras_pkg::FRAME_SIG_B)
			|| (frame_count == tras_pkg::FRAME_SIG_D);

		if ((cur_idx == tras_pkg::LAST_BIT)
			&& (s.esf_mode ? !frame_count[0] : frame_count[0])) begin
			n.link_out = s.shift[tras_pkg::LINK_TAP];
		end

		if (line_in_positive || line_in_negative) begin
			n.zero_run = 6'h00;
			n.alarms.carrier_loss = 1'h0;
		end else if (s.zero_run == tras_pkg::CARRIER_RUN_LAST) begin
			n.alarms.carrier_loss = 1'h1;
		end else begin
			n.zero_run = s.zero_run + 6'h01;
		end

		low_zero = (s.frame_zeros != tras_pkg::BLUE_MIN_ZEROS);
		if (frame_fbit) begin
			n.alarms.blue = low_zero && s.low_prev;
			n.low_prev = low_zero;
			n.frame_zeros = 2'h0;
		end else if (in_slot && !line_bit && low_zero) begin
			n.frame_zeros = s.frame_zeros + 2'h1;
		end

		n.alarms.yellow = line_events.yellow;
		n.alarms.loss_of_sync = line_events.loss_of_sync;

		set_v[tras_pkg::ST_YELLOW] = line_events.yellow;
		set_v[tras_pkg::ST_FBIT_ERR] = line_events.fbit_error;
		set_v[tras_pkg::ST_ZERO_SUB] = line_events.zero_sub;
		set_v[tras_pkg::ST_LOSS_SYNC] = line_events.loss_of_sync;
		set_v[tras_pkg::ST_CARRIER] = n.alarms.carrier_loss;
		set_v[tras_pkg::ST_BLUE] = n.alarms.blue;

		// AXI write address and data latches
		if (s_axi_awvalid && s.awready) begin
			n.aw_held = 1'h1;
			n.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_held = 1'h1;
			n.wdata = s_axi_wdata[7:0];
			n.wstrb0 = s_axi_wstrb[0];
		end
		case (s.waddr)
			tras_pkg::ADDR_CONTROL,
			tras_pkg::ADDR_MARK_LOW,
			tras_pkg::ADDR_MARK_MID,
			tras_pkg::ADDR_MARK_HIGH,
			tras_pkg::ADDR_STATUS,
			tras_pkg::ADDR_STATUS_PEEK,
			tras_pkg::ADDR_MASK,
			tras_pkg::ADDR_VIOL_CNT,
			tras_pkg::ADDR_ERR_CNT,
			tras_pkg::ADDR_CONFIG: wr_map = 1'h1;
			default: wr_map = 1'h0;
		endcase
		wr_go = s.aw_held && s.w_held && !s.bvalid;
		wr_ok = wr_go && wr_map && s.wstrb0;
		if (wr_go) begin
			n.aw_held = 1'h0;
			n.w_held = 1'h0;
			n.bvalid = 1'h1;
			n.bresp = wr_map ? tras_pkg::RESP_OKAY : tras_pkg::RESP_SLVERR;
		end else if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'h0;
		end
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;

		// Register writes
		if (wr_ok) begin
			case (s.waddr)
				tras_pkg::ADDR_CONTROL: n.control = s.wdata;
				tras_pkg::ADDR_MARK_LOW: n.mark[7:0] = s.wdata;
				tras_pkg::ADDR_MARK_MID: n.mark[15:8] = s.wdata;
				tras_pkg::ADDR_MARK_HIGH: n.mark[23:16] = s.wdata;
				tras_pkg::ADDR_MASK: begin
					n.mask = s.wdata;
					clr_v = clr_v | (s.status & ~s.wdata);
				end
				tras_pkg::ADDR_CONFIG: begin
					n.esf_mode = s.wdata[tras_pkg::CFG_ESF_MODE];
				end
				default: begin
				end
			endcase
		end

		if (wr_ok && (s.waddr == tras_pkg::ADDR_VIOL_CNT)) begin
			n.viol_cnt = s.wdata;
			if (s.wdata != tras_pkg::ALL_ONES8) begin
				clr_v[tras_pkg::ST_VIOL_SAT] = 1'h1;
			end
		end else if (line_events.bipolar_violation) begin
			if (s.viol_cnt != tras_pkg::ALL_ONES8) begin
				n.viol_cnt = s.viol_cnt + 8'h01;
			end
			set_v[tras_pkg::ST_VIOL_SAT] =
				(n.viol_cnt == tras_pkg::ALL_ONES8);
		end

		// frame error counters, idle in resync
		esf_ev = s.esf_mode ? (line_events.oof_event | line_events.crc_error)
			: line_events.fbit_error;
		if (wr_ok && (s.waddr == tras_pkg::ADDR_ERR_CNT)) begin
			n.oof_cnt = s.wdata[7:4];
			n.esf_cnt = s.wdata[3:0];
			if (s.wdata != tras_pkg::ALL_ONES8) begin
				clr_v[tras_pkg::ST_ERR_SAT] = 1'h1;
			end
		end else if (!line_events.loss_of_sync) begin
			if (line_events.oof_event) begin
				if (s.oof_cnt != tras_pkg::ALL_ONES4) begin
					n.oof_cnt = s.oof_cnt + 4'h1;
				end
				set_v[tras_pkg::ST_ERR_SAT] = (n.oof_cnt == tras_pkg::ALL_ONES4);
			end
			if (esf_ev) begin
				if (s.esf_cnt != tras_pkg::ALL_ONES4) begin
					n.esf_cnt = s.esf_cnt + 4'h1;
				end
				if (n.esf_cnt == tras_pkg::ALL_ONES4) begin
					set_v[tras_pkg::ST_ERR_SAT] = 1'h1;
				end
			end
		end

		// AXI read decode
		rd_map = 1'h1;
		case (s_axi_araddr)
			tras_pkg::ADDR_CONTROL: rd_byte = s.control;
			tras_pkg::ADDR_MARK_LOW: rd_byte = s.mark[7:0];
			tras_pkg::ADDR_MARK_MID: rd_byte = s.mark[15:8];
			tras_pkg::ADDR_MARK_HIGH: rd_byte = s.mark[23:16];
			tras_pkg::ADDR_STATUS: rd_byte = s.status;
			tras_pkg::ADDR_STATUS_PEEK: rd_byte = s.status;
			tras_pkg::ADDR_MASK: rd_byte = s.mask;
			tras_pkg::ADDR_VIOL_CNT: rd_byte = s.viol_cnt;
			tras_pkg::ADDR_ERR_CNT: rd_byte = {s.oof_cnt, s.esf_cnt};
			tras_pkg::ADDR_CONFIG: rd_byte = {7'h00, s.esf_mode};
			default: begin
				rd_byte = 8'h00;
				rd_map = 1'h0;
			end
		endcase
		rd_go = s_axi_arvalid && s.arready;
		if (rd_go) begin
			n.rvalid = 1'h1;
			n.rdata = {24'h000000, rd_byte};
			n.rresp = rd_map ? tras_pkg::RESP_OKAY : tras_pkg::RESP_SLVERR;
			if (s_axi_araddr == tras_pkg::ADDR_STATUS) begin
				clr_v = clr_v | tras_pkg::DIRECT_BITS;
			end
		end else if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'h0;
		end
		n.arready = !n.rvalid;

		n.status = (s.status & ~clr_v) | set_v;
		n.irq = |(n.status & n.mask);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign rx_serial_out = s.serial_out;
	assign rx_signaling_out = s.sig_out;
	assign rx_link_out = s.link_out;
	assign rx_multiframe_sync = s.mf_sync;
	assign rx_signaling_frame_ind = s.sig_frame;
	assign rx_signaling_select = s.sig_select;
	assign alarm_out = s.alarms;
	assign irq = s.irq;

endmodule : tras_rx_alarm_signaling

// ### tras_line_model.sv
// Line model: framed bipolar stream with superframe timing.
// Assumes one line bit per clock; quiet forces an all-zero line.
`timescale 1ns/1ps
module tras_line_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Control
	input wire logic quiet,
	// Line and timing
	output logic line_in_positive,
	output logic line_in_negative,
	output logic frame_fbit,
	output logic [4:0] frame_count
);
	logic [7:0] pos_reg;
	// F bit slot then 192 channel bits
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pos_reg <= 8'h00;
			frame_count <= 5'h01;
		end else if (pos_reg == 8'hc0) begin
			pos_reg <= 8'h00;
			frame_count <= (frame_count == 5'h0c) ? 5'h01 : frame_count + 5'h01;
		end else begin
			pos_reg <= pos_reg + 8'h01;
		end
	end
	assign frame_fbit = !reset && pos_reg == 8'h00;
	assign line_in_positive = !quiet && pos_reg[1];
	assign line_in_negative = !quiet && pos_reg[2] && !pos_reg[1];
endmodule : tras_line_model

// ### tras_rx_alarm_signaling_asserts.sv
// Checker for the receive alarm and signaling block.
// Assumes code insertion stays disabled and one clock domain.
`timescale 1ns/1ps
module tras_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Line side
	input wire logic line_in_positive,
	input wire logic line_in_negative,
	input wire logic frame_fbit,
	input wire logic [4:0] frame_count,
	input wire tras_pkg::tras_line_events_t line_events,
	// Outputs
	input wire logic rx_serial_out,
	input wire logic rx_signaling_out,
	input wire logic rx_link_out,
	input wire logic rx_multiframe_sync,
	input wire logic rx_signaling_frame_ind,
	input wire logic rx_signaling_select,
	input wire tras_pkg::tras_alarms_t alarm_out,
	input wire logic irq
);
	logic [3:0] live_reg;
	logic [5:0] zrun_reg;
	logic [7:0] slot_reg;
	logic zero;
	assign zero = !line_in_positive && !line_in_negative;
	// Cycles since reset, zero run and bit slot
	always_ff @(posedge core_clk) begin
		if (reset) begin
			live_reg <= 4'h0;
			zrun_reg <= 6'h00;
			slot_reg <= 8'h00;
		end else begin
			live_reg <= live_reg + {3'h0, live_reg != 4'hf};
			zrun_reg <= zero ? zrun_reg + {5'h00, zrun_reg != 6'h3f} : 6'h00;
			slot_reg <= frame_fbit ? 8'h01 : slot_reg + 8'h01;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_serial_lag: assert property (live_reg == 4'hf |->
		rx_serial_out == ($past(line_in_positive, 14) |
		$past(line_in_negative, 14))) else $error("serial lag wrong");
	chk_sig_edge: assert property (live_reg > 4'h2 &&
		$changed(rx_signaling_out) |-> $past(slot_reg[2:0]) == 3'h1)
		else $error("signaling changed mid channel");
	chk_sig_lsb: assert property (live_reg == 4'hf &&
		slot_reg[2:0] == 3'h1 && slot_reg != 8'h01 |->
		rx_signaling_out == rx_serial_out)
		else $error("signaling not channel lsb");
	chk_link_edge: assert property (live_reg > 4'h2 &&
		$changed(rx_link_out) |-> $past(slot_reg) == 8'hc0 &&
		$past(frame_count[0])) else $error("link changed off boundary");
	chk_mf_sync: assert property (live_reg != 4'h0 |->
		rx_multiframe_sync == ($past(frame_count) == 5'h01))
		else $error("multiframe sync wrong");
	chk_sig_frame: assert property (live_reg != 4'h0 |->
		rx_signaling_frame_ind == ($past(frame_count) inside {5'h06,
		5'h0c, 5'h12, 5'h18})) else $error("signaling frame wrong");
	chk_sig_select: assert property (live_reg != 4'h0 |->
		rx_signaling_select == ($past(frame_count) inside {5'h0c, 5'h18}))
		else $error("signaling select wrong");
	chk_carrier_set: assert property (zero && zrun_reg == 6'h1f |=>
		alarm_out.carrier_loss) else $error("carrier loss not raised");
	chk_carrier_clr: assert property (!zero |=>
		!alarm_out.carrier_loss) else $error("carrier loss stuck");
	chk_sync_copy: assert property (live_reg != 4'h0 |->
		alarm_out.loss_of_sync == $past(line_events.loss_of_sync))
		else $error("sync loss output wrong");
	chk_yellow_copy: assert property (live_reg != 4'h0 |->
		alarm_out.yellow == $past(line_events.yellow))
		else $error("yellow output wrong");
	cov_carrier: cover property ($rose(alarm_out.carrier_loss));
	cov_irq: cover property ($rose(irq));
	cov_sig_frame: cover property ($rose(rx_signaling_frame_ind));
endmodule : tras_checker

bind tras_rx_alarm_signaling tras_checker chk_i (.core_clk, .reset,
	.line_in_positive, .line_in_negative, .frame_fbit, .frame_count,
	.line_events, .rx_serial_out, .rx_signaling_out, .rx_link_out,
	.rx_multiframe_sync,
	.rx_signaling_frame_ind, .rx_signaling_select, .alarm_out, .irq);

// ### testbench.sv
// Bench: AXI4-Lite register tasks and alarm scenarios.
// Assumes the line model supplies stream and frame timing.
`timescale 1ns/1ps
module testbench;
	logic core_clk, reset, quiet, irq, frame_fbit;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, line_in_positive, line_in_negative;
	logic rx_serial_out, rx_signaling_out, rx_link_out, rx_multiframe_sync;
	logic rx_signaling_frame_ind, rx_signaling_select;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [3:0] s_axi_wstrb;
	logic [4:0] frame_count;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rd_val;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [7:0] mv [3] = '{8'h01, 8'h5a, 8'h80};
	tras_pkg::tras_line_events_t line_events;
	tras_pkg::tras_alarms_t alarm_out;
	int mismatches = 0, checks_done = 0, cycles = 0;
	localparam logic [7:0] a_st = tras_pkg::ADDR_STATUS;
	localparam logic [7:0] a_pk = tras_pkg::ADDR_STATUS_PEEK;
	localparam logic [7:0] a_mk = tras_pkg::ADDR_MASK;

	tras_rx_alarm_signaling dut (.core_clk, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.line_in_positive, .line_in_negative, .frame_fbit, .frame_count,
		.line_events, .rx_serial_out, .rx_signaling_out, .rx_link_out,
		.rx_multiframe_sync, .rx_signaling_frame_ind,
		.rx_signaling_select, .alarm_out, .irq);
	tras_line_model line_i (.core_clk, .reset, .quiet, .line_in_positive,
		.line_in_negative, .frame_fbit, .frame_count);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Cycle ceiling against a hung handshake
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_val = s_axi_rdata[7:0];
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(rd_val, exp);
	endtask : rchk

	task automatic pulse(input logic [6:0] e);
		@(posedge core_clk);
		line_events <= e;
		@(posedge core_clk);
		line_events <= 7'h00;
	endtask : pulse

	task automatic close_out();
		$display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	initial begin
		{reset, quiet, s_axi_wstrb, line_events} = 13'h1780;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		s_axi_wdata = 32'h00000000;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rchk(a_pk, 8'h00);
		foreach (mv[i]) wr(tras_pkg::ADDR_MARK_LOW + 8'(4 * i), mv[i]);
		foreach (mv[i]) rchk(tras_pkg::ADDR_MARK_LOW + 8'(4 * i), mv[i]);
		wr(8'h40, 8'h11);
		chk({6'h00, resp}, {6'h00, tras_pkg::RESP_SLVERR});
		rchk(8'h40, 8'h00);
		chk({6'h00, resp}, {6'h00, tras_pkg::RESP_SLVERR});
		$display("Test registers done");
		wr(a_mk, 8'h10);
		quiet <= 1'b1;
		repeat (40) @(posedge core_clk);
		chk({7'h00, alarm_out.carrier_loss}, 8'h01);
		chk({7'h00, irq}, 8'h01);
		rchk(a_st, 8'h10);
		rchk(a_st, 8'h10);
		quiet <= 1'b0;
		repeat (4) @(posedge core_clk);
		rchk(a_st, 8'h10);
		rchk(a_st, 8'h00);
		chk({7'h00, irq}, 8'h00);
		$display("Test carrier done");
		wr(a_mk, 8'h04);
		pulse(7'h10);
		rchk(a_pk, 8'h04);
		rchk(a_pk, 8'h04);
		chk({7'h00, irq}, 8'h01);
		wr(a_mk, 8'h00);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq}, 8'h00);
		rchk(a_pk, 8'h00);
		pulse(7'h10);
		rchk(a_st, 8'h04);
		chk({7'h00, irq}, 8'h00);
		rchk(a_st, 8'h00);
		$display("Test mask done");
		wr(a_mk, 8'hc0);
		wr(tras_pkg::ADDR_VIOL_CNT, 8'hfd);
		pulse(7'h08);
		rchk(a_pk, 8'h00);
		pulse(7'h08);
		rchk(a_st, 8'h80);
		rchk(a_st, 8'h80);
		rchk(tras_pkg::ADDR_VIOL_CNT, 8'hff);
		chk({7'h00, irq}, 8'h01);
		wr(tras_pkg::ADDR_VIOL_CNT, 8'h00);
		rchk(a_pk, 8'h00);
		$display("Test violation done");
		wr(tras_pkg::ADDR_ERR_CNT, 8'hee);
		pulse(7'h24);
		rchk(tras_pkg::ADDR_ERR_CNT, 8'hff);
		rchk(a_st, 8'h48);
		rchk(a_st, 8'h40);
		wr(tras_pkg::ADDR_ERR_CNT, 8'h00);
		rchk(a_pk, 8'h00);
		$display("Test counters done");
		line_events <= 7'h41;
		repeat (3) @(posedge core_clk);
		chk({4'h0, alarm_out}, 8'h09);
		line_events <= 7'h00;
		repeat (2) @(posedge core_clk);
		rchk(a_st, 8'h21);
		rchk(a_st, 8'h00);
		$display("Test alarms done");
		close_out();
	end
endmodule : testbench
